//--- core/acc_top.sv
// comparator control register, pin steering and wake logic over apb
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "acc_map.svh"
module acc_top
	import acc_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog comparator
	input wire logic compare_raw,
	output logic compare_power,
	output logic negative_input_select,
	output logic positive_input_select,
	// core side
	input wire logic sleep_enter,
	input wire logic timer_clock_source_select,
	input wire logic pin_two_dir_timer,
	output logic timer_clock_out,
	output logic timer_source_is_compare,
	// pins
	output logic port_pin_two_out,
	output logic port_pin_two_oe,
	output logic pins_analog,
	output logic wake_reset
);
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] stat_q, stat_d;
	acc_power_t pwr_q, pwr_d;
	logic result_s, latched, changed;
	logic [31:0] rdata_d;
	logic en, acc_w, acc_r, hit_ctrl, hit_stat, hit_sys, miss;
	logic pol_res, wake_set, ctrl_rd, stat_wr;

	acc_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(compare_raw),
		.sync_out(result_s)
	);

	// keeps comparing in sleep while enabled
	assign en = ctrl_q[`ACC_B_EN];
	assign acc_w = psel && penable && pwrite;
	assign acc_r = psel && penable && !pwrite;
	assign hit_ctrl = paddr == `ACC_CTRL_OFS;
	assign hit_stat = paddr == `ACC_STAT_OFS;
	assign hit_sys = paddr == `ACC_SYS_OFS;
	assign miss = !(hit_ctrl || hit_stat || hit_sys);
	assign ctrl_rd = acc_r && hit_ctrl;
	assign stat_wr = acc_w && hit_stat;

	acc_change_det u_det (
		.pclk(pclk),
		.presetn(presetn),
		.latch(ctrl_rd),
		.level(result_s),
		.latched_q(),
		.changed(changed)
	);

	assign pol_res = en ? (result_s ~^ ctrl_q[`ACC_B_POL]) : result_s;
	assign wake_set = en && !ctrl_q[`ACC_B_WAKE_DIS] &&
		stat_q[`ACC_S_LATCHED] && pwr_q == ACC_ASLEEP && changed;

	always_comb begin
		ctrl_d = ctrl_q;
		if (acc_w && hit_ctrl)
			ctrl_d[6:0] = pwdata[6:0];
		ctrl_d[`ACC_B_RESULT] = result_s;
	end

	always_comb begin
		stat_d = stat_q;
		if (stat_wr && !pwdata[`ACC_S_WAKE])
			stat_d[`ACC_S_WAKE] = 1'b0;
		if (stat_wr && !pwdata[`ACC_S_PINWAKE])
			stat_d[`ACC_S_PINWAKE] = 1'b0;
		if (ctrl_rd)
			stat_d[`ACC_S_LATCHED] = 1'b1;
		if (wake_set) begin
			stat_d[`ACC_S_WAKE] = 1'b1;
			stat_d[`ACC_S_PINWAKE] = 1'b0;
			stat_d[`ACC_S_TO_N] = 1'b1;
			stat_d[`ACC_S_PD_N] = 1'b0;
		end
		if (sleep_enter)
			stat_d[`ACC_S_PD_N] = 1'b0;
		stat_d[`ACC_S_SLEEP] = (pwr_d == ACC_ASLEEP);
	end

	always_comb begin
		case (pwr_q)
			ACC_RUN: pwr_d = sleep_enter ? ACC_ASLEEP : ACC_RUN;
			ACC_ASLEEP: pwr_d = wake_set ? ACC_WOKEN : ACC_ASLEEP;
			ACC_WOKEN: pwr_d = ACC_RUN;
			default: pwr_d = ACC_RUN;
		endcase
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (hit_ctrl)
			rdata_d[7:0] = ctrl_q;
		else if (hit_stat)
			rdata_d[7:0] = stat_q;
		else if (hit_sys)
			rdata_d[1:0] = {timer_clock_source_select, pwr_q == ACC_ASLEEP};
	end

	// control register all ones at power-on, comparator off during reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `ACC_CTRL_RST;
			stat_q <= `ACC_STAT_RST;
			pwr_q <= ACC_RUN;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			compare_power <= 1'b0;
			negative_input_select <= 1'b1;
			positive_input_select <= 1'b1;
			timer_clock_out <= 1'b0;
			timer_source_is_compare <= 1'b0;
			port_pin_two_out <= 1'b0;
			port_pin_two_oe <= 1'b0;
			pins_analog <= 1'b1;
			wake_reset <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			stat_q <= stat_d;
			pwr_q <= pwr_d;
			prdata <= rdata_d;
			pready <= psel && !penable;
			pslverr <= psel && !penable && miss;
			compare_power <= en;
			negative_input_select <= !en || ctrl_q[`ACC_B_NSEL];
			positive_input_select <= !en || ctrl_q[`ACC_B_PSEL];
			timer_source_is_compare <= en && !ctrl_q[`ACC_B_TSRC_N];
			timer_clock_out <= pol_res;
			port_pin_two_out <= pol_res;
			port_pin_two_oe <= (en && !ctrl_q[`ACC_B_PIN_DIS]) ||
				(!(en && !ctrl_q[`ACC_B_PIN_DIS]) && pin_two_dir_timer);
			pins_analog <= ctrl_q[`ACC_B_EN];
			wake_reset <= pwr_q == ACC_WOKEN;
		end
	end
endmodule

//--- core/acc_map.svh
// offsets, field positions, reset values and counts for comparator control
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
`define ACC_CTRL_OFS 12'h000
`define ACC_STAT_OFS 12'h004
`define ACC_SYS_OFS 12'h008
`define ACC_B_RESULT 7
`define ACC_B_PIN_DIS 6
`define ACC_B_POL 5
`define ACC_B_TSRC_N 4
`define ACC_B_EN 3
`define ACC_B_NSEL 2
`define ACC_B_PSEL 1
`define ACC_B_WAKE_DIS 0
`define ACC_CTRL_RST 8'hff
`define ACC_S_WAKE 0
`define ACC_S_PINWAKE 1
`define ACC_S_TO_N 2
`define ACC_S_PD_N 3
`define ACC_S_LATCHED 4
`define ACC_S_SLEEP 5
`define ACC_STAT_RST 8'h0c
`define ACC_Y_SLEEP 0
`define ACC_Y_TMRSEL 1
`define ACC_Y_SYNC_STAGES 2
`endif

//--- core/acc_pkg.sv
// types for the comparator control block
package acc_pkg;
	typedef enum logic [1:0] {
		ACC_RUN = 2'b00,
		ACC_ASLEEP = 2'b01,
		ACC_WOKEN = 2'b11
	} acc_power_t;
endpackage

//--- core/acc_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
module acc_sync (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// level in and out
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

//--- core/acc_change_det.sv
// detects a change of the synchronised result against a latched copy
`timescale 1ns/10ps
module acc_change_det (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// sample control and level
	input wire logic latch,
	input wire logic level,
	// outputs
	output logic latched_q,
	output logic changed
);
	logic ref_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_q <= 1'b1;
		end else if (latch) begin
			ref_q <= level;
		end
	end
	assign latched_q = ref_q;
	assign changed = (level != ref_q);
endmodule

//--- tb/acc_monitor.sv
// assertions on the comparator control ports
`timescale 1ns/10ps
module acc_monitor (
	// apb
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	// comparator and pins
	input logic compare_power,
	input logic negative_input_select,
	input logic positive_input_select,
	input logic timer_clock_out,
	input logic timer_source_is_compare,
	input logic port_pin_two_out,
	input logic wake_reset
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_ANSWER: assert property (psel && !penable |=> pready)
		else $error("no answer");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("ready held");
	AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("bad error");
	AST_DIS_SEL: assert property (!compare_power |->
		negative_input_select && positive_input_select) else $error("sel");
	AST_TSRC: assert property (timer_source_is_compare |-> compare_power)
		else $error("tsrc");
	AST_POL: assert property (timer_clock_out == port_pin_two_out)
		else $error("pol");
	AST_WAKE_EN: assert property (wake_reset |-> $past(compare_power))
		else $error("wake off");
	AST_WAKE: assert property (wake_reset |=> !wake_reset)
		else $error("wake held");
endmodule
bind acc_top acc_monitor mon (.pclk, .presetn, .psel, .penable, .prdata,
	.pready, .pslverr, .compare_power, .negative_input_select,
	.positive_input_select, .timer_clock_out, .timer_source_is_compare,
	.port_pin_two_out, .wake_reset);

//--- tb/acc_top_tb.sv
// bench for the comparator control block
`timescale 1ns/10ps
`define CHK(a, e) begin \
	num_checks++; \
	if ((a) !== (e)) begin \
		n_errors++; \
		$display("mismatch %0t check %0d", $time, num_checks); \
	end \
end
module acc_top_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic compare_raw = 1, sleep_enter = 0, timer_clock_source_select = 1;
	logic pin_two_dir_timer = 0, pready, pslverr, er, w;
	logic compare_power, negative_input_select, positive_input_select;
	logic timer_clock_out, timer_source_is_compare, port_pin_two_out;
	logic port_pin_two_oe, pins_analog, wake_reset;
	int n_errors = 0, num_checks = 0;
	acc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .compare_raw, .compare_power,
		.negative_input_select, .positive_input_select, .sleep_enter,
		.timer_clock_source_select, .pin_two_dir_timer, .timer_clock_out,
		.timer_source_is_compare, .port_pin_two_out, .port_pin_two_oe,
		.pins_analog, .wake_reset);
	always #50 pclk = ~pclk;
	task automatic apb(input logic wr, input logic [11:0] a, input int d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task end_sim;
		if (n_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(0, 12'h000, 0);
		`CHK(rd, 32'h0000_00ff)
		`CHK(pins_analog, 1'h1)
		apb(0, 12'h00c, 0);
		`CHK({er, rd}, 33'h1_0000_0000)
		compare_raw <= 1'h0;
		apb(1, 12'h000, 'ha8);
		repeat (4) @(posedge pclk);
		apb(0, 12'h000, 0);
		`CHK(rd, 32'h0000_0028)
		`CHK({compare_power, timer_source_is_compare}, 2'h3)
		`CHK(port_pin_two_oe, 1'h1)
		`CHK({negative_input_select, positive_input_select}, 2'h0)
		`CHK(port_pin_two_out, 1'h0)
		compare_raw <= 1'h1;
		repeat (4) @(posedge pclk);
		`CHK(port_pin_two_out, 1'h1)
		apb(0, 12'h000, 0);
		`CHK(rd, 32'h0000_00a8)
		sleep_enter <= 1'h1;
		@(posedge pclk);
		sleep_enter <= 1'h0;
		compare_raw <= 1'h0;
		w = 0;
		repeat (20) begin
			@(posedge pclk);
			if (wake_reset === 1'h1)
				w = 1;
		end
		`CHK(w, 1'h1)
		apb(0, 12'h004, 0);
		`CHK(rd[3:0], 4'h5)
		apb(1, 12'h004, 0);
		apb(0, 12'h004, 0);
		`CHK(rd[0], 1'h0)
		apb(0, 12'h008, 0);
		`CHK(rd[1:0], 2'h2)
		apb(1, 12'h000, 'h0e);
		repeat (3) @(posedge pclk);
		`CHK(port_pin_two_out, 1'h1)
		`CHK({negative_input_select, positive_input_select}, 2'h3)
		apb(1, 12'h000, 0);
		repeat (3) @(posedge pclk);
		`CHK({compare_power, timer_source_is_compare}, 2'h0)
		`CHK(port_pin_two_oe, 1'h0)
		`CHK(pins_analog, 1'h0)
		pin_two_dir_timer <= 1'h1;
		repeat (2) @(posedge pclk);
		`CHK(port_pin_two_oe, 1'h1)
		end_sim;
	end
	initial begin
		#100000;
		n_errors++;
		end_sim;
	end
endmodule
